/* timer_counter.v */
// Function
// - A 16-bit counter counts up or down and feeds an independent compare unit.
// - Four modes are selectable: watchdog, clear on compare, fast PWM, phase-frequency PWM.
// - The count clock source is selectable and passes a programmable prescaler.
// - Overflow, compare match and input capture are three independent interrupt sources.
// - A separate wake-up interrupt goes to the standby controller.
// - PWM output is glitch free and its period is set by a register.
// - With the bus in use and a non-PWM mode, a synchronised trigger rise captures the count.
// - Without the bus the interrupt is the one-cycle overflow event pulse; with it, three registers govern it.
// - Control and status registers are reached by fabric logic over the register bus.
// - A stand-alone mode runs from preloaded control values and the direct reset input.
// - The reset pin stays effective through a reset-enable bit preloaded to enabled.
// - The compare output follows compare matches per mode and the count reloads each period.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "timer_counter_regs.vh"
`default_nettype none

module timer_counter (
	// Clock and reset
	input wire core_clk_in,
	input wire reset_n_in,
	// Avalon-MM register slave
	input wire [2:0] address_in,
	input wire read_in,
	input wire write_in,
	input wire [31:0] writedata_in,
	output reg [31:0] readdata_out,
	output wire waitrequest_out,
	// Operating mode strap: high when the register bus is used
	input wire bus_mode_in,
	// Timer pins
	input wire timer_clock_in,
	input wire timer_reset_n_in,
	input wire capture_trigger_in,
	output reg compare_output_out,
	output reg timer_irq_out,
	output reg wake_irq_out
);

	//////////////////////////////////////////////////////////////////////
	// Declarations
	reg [2:0] clk_sync, rst_sync, cap_sync;
	reg clk_level, rst_level, cap_level;
	reg ack;
	reg [`TC_CTRL_W-1:0] ctrl;
	reg [15:0] top, cmp, top_act, cmp_act;
	reg [15:0] count_value;
	reg [15:0] capture_value_reg;
	reg [`TC_EV_W-1:0] status;
	reg [`TC_EV_W-1:0] irq_enable;
	reg [9:0] psc_cnt;
	reg count_down;
	reg [15:0] next_count;
	reg next_down;
	reg ev_ovf, ev_cmp, period_end;
	wire [1:0] mode;
	wire pwm_mode;
	wire clk_edge, cap_edge, src_tick, tick;
	wire bus_write, bus_read, timer_clear;
	wire [`TC_EV_W-1:0] events;
	wire [`TC_EV_W-1:0] clr_mask;

	// Prescaler terminal count for a 3-bit select
	function [9:0] psc_limit;
		input [2:0] sel;
		begin
			case (sel)
				3'h0: psc_limit = 10'h000;
				3'h1: psc_limit = 10'h001;
				3'h2: psc_limit = 10'h003;
				3'h3: psc_limit = 10'h007;
				3'h4: psc_limit = 10'h03f;
				3'h5: psc_limit = 10'h0ff;
				default: psc_limit = 10'h3ff;
			endcase
		end
	endfunction
	// Register index decode
	function hit;
		input [2:0] addr;
		input [2:0] idx;
		begin
			hit = (addr == idx);
		end
	endfunction
	//////////////////////////////////////////////////////////////////////
	// Pin synchronisers: three stages, level changes when stages 2 and 3 agree
	// trigger synchronised in parallel with clock and reset
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clk_sync <= 3'h0;
			rst_sync <= 3'h7;
			cap_sync <= 3'h0;
			clk_level <= 1'b0;
			rst_level <= 1'b1;
			cap_level <= 1'b0;
		end else begin
			clk_sync <= {clk_sync[1:0], timer_clock_in};
			rst_sync <= {rst_sync[1:0], timer_reset_n_in};
			cap_sync <= {cap_sync[1:0], capture_trigger_in};
			if (clk_sync[1] == clk_sync[2])
				clk_level <= clk_sync[2];
			if (rst_sync[1] == rst_sync[2])
				rst_level <= rst_sync[2];
			if (cap_sync[1] == cap_sync[2])
				cap_level <= cap_sync[2];
		end
	end

	assign cap_edge = cap_sync[1] & cap_sync[2] & ~cap_level;
	assign clk_edge = clk_sync[1] & clk_sync[2] & ~clk_level;

	//////////////////////////////////////////////////////////////////////
	// Register bus handshake: one wait cycle per access
	// bus slave access
	assign waitrequest_out = (read_in | write_in) & ~ack;
	assign bus_write = write_in & ack & bus_mode_in;
	assign bus_read = read_in & ~ack;
	assign clr_mask = (bus_write && hit(address_in, `TC_REG_CLR)) ?
		writedata_in[`TC_EV_W-1:0] : {`TC_EV_W{1'b0}};

	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			ack <= 1'b0;
		else
			ack <= (read_in | write_in) & ~ack;
	end

	// Read data registered one cycle before the completing edge
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			readdata_out <= 32'h00000000;
		end else if (bus_read) begin
			case (address_in)
				`TC_REG_CTRL: readdata_out <= {24'h000000, ctrl};
				`TC_REG_TOP: readdata_out <= {16'h0000, top};
				`TC_REG_CMP: readdata_out <= {16'h0000, cmp};
				`TC_REG_CNT: readdata_out <= {16'h0000, count_value};
				`TC_REG_CAP: readdata_out <= {16'h0000, capture_value_reg};
				`TC_REG_STAT: readdata_out <= {29'h0, status};
				`TC_REG_IEN: readdata_out <= {29'h0, irq_enable};
				default: readdata_out <= 32'h00000000;
			endcase
		end
	end

	// Control registers, reset to the preloaded values
	// reset-enable preloaded set
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl <= `TC_CTRL_RESET;
			top <= `TC_TOP_RESET;
			cmp <= `TC_CMP_RESET;
			irq_enable <= {`TC_EV_W{1'b0}};
		end else if (bus_write) begin
			if (hit(address_in, `TC_REG_CTRL))
				ctrl <= writedata_in[`TC_CTRL_W-1:0];
			if (hit(address_in, `TC_REG_TOP))
				top <= writedata_in[15:0];
			if (hit(address_in, `TC_REG_CMP))
				cmp <= writedata_in[15:0];
			if (hit(address_in, `TC_REG_IEN))
				irq_enable <= writedata_in[`TC_EV_W-1:0];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Clock source and prescaler
	assign mode = ctrl[`TC_MODE_MSB:`TC_MODE_LSB];
	assign pwm_mode = (mode == `TC_MODE_FPWM) | (mode == `TC_MODE_PFC);
	assign timer_clear = ctrl[`TC_RSTEN_BIT] & ~rst_level;
	assign src_tick = ctrl[`TC_CLKSEL_BIT] ? clk_edge : 1'b1;
	assign tick = src_tick && (psc_cnt == psc_limit(ctrl[`TC_PSC_MSB:`TC_PSC_LSB]));

	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			psc_cnt <= `TC_PSC_ZERO;
		else if (timer_clear || tick)
			psc_cnt <= `TC_PSC_ZERO;
		else if (src_tick)
			psc_cnt <= psc_cnt + 10'h001;
	end

	//////////////////////////////////////////////////////////////////////
	// Next count per mode
	// four operating modes
	always @* begin
		next_count = count_value;
		next_down = count_down;
		ev_ovf = 1'b0;
		ev_cmp = 1'b0;
		period_end = 1'b0;
		case (mode)
			`TC_MODE_WDT: begin
				next_down = 1'b1;
				if (count_value == `COUNT_VALUE_ZERO) begin
					next_count = top_act;
					ev_ovf = 1'b1;
					period_end = 1'b1;
				end else begin
					next_count = count_value - `COUNT_VALUE_ONE;
				end
				ev_cmp = (count_value == cmp_act);
			end
			`TC_MODE_CTC: begin
				next_down = 1'b0;
				ev_cmp = (count_value == cmp_act);
				ev_ovf = (count_value == `TC_TOP_RESET);
				period_end = ev_cmp;
				next_count = ev_cmp ? `COUNT_VALUE_ZERO : count_value + `COUNT_VALUE_ONE;
			end
			`TC_MODE_FPWM: begin
				next_down = 1'b0;
				ev_cmp = (count_value == cmp_act);
				if (count_value >= top_act) begin
					next_count = `COUNT_VALUE_ZERO;
					ev_ovf = 1'b1;
					period_end = 1'b1;
				end else begin
					next_count = count_value + `COUNT_VALUE_ONE;
				end
			end
			`TC_MODE_PFC: begin
				ev_cmp = (count_value == cmp_act);
				if (!count_down && count_value >= top_act) begin
					next_down = 1'b1;
					next_count = count_value - `COUNT_VALUE_ONE;
				end else if (count_down && count_value == `COUNT_VALUE_ZERO) begin
					next_down = 1'b0;
					next_count = `COUNT_VALUE_ONE;
					ev_ovf = 1'b1;
					period_end = 1'b1;
				end else if (count_down) begin
					next_count = count_value - `COUNT_VALUE_ONE;
				end else begin
					next_count = count_value + `COUNT_VALUE_ONE;
				end
			end
			default: next_count = count_value;
		endcase
	end

	// Counter, direction and period shadows
	// 16-bit counter
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_value <= `COUNT_VALUE_ZERO;
			count_down <= 1'b0;
			top_act <= `TC_TOP_RESET;
			cmp_act <= `TC_CMP_RESET;
		end else if (timer_clear) begin
			count_value <= `COUNT_VALUE_ZERO;
			count_down <= 1'b0;
			top_act <= top;
			cmp_act <= cmp;
		end else if (bus_write && hit(address_in, `TC_REG_CNT)) begin
			count_value <= writedata_in[15:0];
		end else if (tick) begin
			count_value <= next_count;
			count_down <= next_down;
			// shadows load at period end in PWM modes, on every tick otherwise
			if (period_end || !pwm_mode) begin
				top_act <= top;
				cmp_act <= cmp;
			end
		end
	end

	// Compare output from a flop
	// waveform from compare
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			compare_output_out <= 1'b0;
		else if (timer_clear)
			compare_output_out <= 1'b0;
		else if (pwm_mode)
			compare_output_out <= (count_value < cmp_act);
		else if (tick && ev_cmp)
			compare_output_out <= ~compare_output_out;
	end

	//////////////////////////////////////////////////////////////////////
	// Input capture
	// capture in non-PWM modes with bus
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			capture_value_reg <= `COUNT_VALUE_ZERO;
		else if (cap_edge && ctrl[`TC_CAPEN_BIT] && bus_mode_in && !pwm_mode)
			capture_value_reg <= count_value;
	end

	//////////////////////////////////////////////////////////////////////
	// Interrupt status, clear and enable
	// three independent sources
	assign events[`TC_EV_OVF] = tick & ev_ovf & ~timer_clear;
	assign events[`TC_EV_CMP] = tick & ev_cmp & ~timer_clear;
	assign events[`TC_EV_CAP] = cap_edge & ctrl[`TC_CAPEN_BIT] & bus_mode_in & ~pwm_mode;

	// Set wins over clear
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			status <= {`TC_EV_W{1'b0}};
		else
			status <= (status & ~clr_mask) | events;
	end

	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			timer_irq_out <= 1'b0;
			wake_irq_out <= 1'b0;
		end else begin
			if (bus_mode_in)
				timer_irq_out <= |(((status & ~clr_mask) | events) & irq_enable);
			else
				timer_irq_out <= events[`TC_EV_OVF];
			wake_irq_out <= |(events & (bus_mode_in ? irq_enable : 3'h1));
		end
	end

endmodule // timer_counter

`default_nettype wire

/* timer_counter_regs.vh */
`ifndef TIMER_COUNTER_REGS_VH
`define TIMER_COUNTER_REGS_VH
// Word indexes on the register bus
`define TC_REG_CTRL 3'h0
`define TC_REG_TOP 3'h1
`define TC_REG_CMP 3'h2
`define TC_REG_CNT 3'h3
`define TC_REG_CAP 3'h4
`define TC_REG_STAT 3'h5
`define TC_REG_CLR 3'h6
`define TC_REG_IEN 3'h7
// Control fields
`define TC_MODE_LSB 0
`define TC_MODE_MSB 1
`define TC_CLKSEL_BIT 2
`define TC_PSC_LSB 3
`define TC_PSC_MSB 5
`define TC_CAPEN_BIT 6
`define TC_RSTEN_BIT 7
`define TC_CTRL_W 8
// Mode encodings
`define TC_MODE_WDT 2'h0
`define TC_MODE_CTC 2'h1
`define TC_MODE_FPWM 2'h2
`define TC_MODE_PFC 2'h3
// Status and interrupt bit positions
`define TC_EV_OVF 0
`define TC_EV_CMP 1
`define TC_EV_CAP 2
`define TC_EV_W 3
// Preloaded configuration values
`define TC_CTRL_RESET 8'h84
`define TC_TOP_RESET 16'hffff
`define TC_CMP_RESET 16'h8000
`define COUNT_VALUE_ZERO 16'h0000
`define COUNT_VALUE_ONE 16'h0001
`define TC_PSC_ZERO 10'h000
`endif

/* avalon_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Fabric-side register bus master
module avalon_host (
	// Clock and slave answer
	input wire logic core_clk_in,
	input wire logic waitrequest_out,
	input wire logic [31:0] readdata_out,
	// Request lines
	output logic [2:0] address_in,
	output logic read_in,
	output logic write_in,
	output logic [31:0] writedata_in
);
	int stalls = 0;
	// Idle bus at time zero
	initial begin
		address_in = 3'h0;
		read_in = 1'b0;
		write_in = 1'b0;
		writedata_in = 32'h0;
	end
	task automatic xfer(input logic rd, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		@(posedge core_clk_in);
		address_in <= a;
		writedata_in <= d;
		read_in <= rd;
		write_in <= !rd;
		// Answer sampled on the rising edge; release at that same edge
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk_in);
			if (!waitrequest_out) break;
		end
		if (i == 20) stalls++;
		q = readdata_out;
		read_in <= 1'b0;
		write_in <= 1'b0;
	endtask
endmodule // avalon_host
`default_nettype wire

/* timer_counter_properties.sv */
`timescale 1ns/1ps
`include "timer_counter_regs.vh"
`default_nettype none
module timer_counter_properties (
	// Watched ports
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic [2:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] writedata_in,
	input wire logic [31:0] readdata_out,
	input wire logic waitrequest_out,
	input wire logic bus_mode_in,
	input wire logic compare_output_out,
	input wire logic timer_irq_out,
	input wire logic wake_irq_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	wire acc = read_in && !waitrequest_out;
	a_wait_one_cycle: assert property ($rose(read_in) || $rose(write_in) |->
		waitrequest_out ##1 !waitrequest_out) else $error("wait not one cycle");
	a_wait_idle_low: assert property (!read_in && !write_in |-> !waitrequest_out)
		else $error("wait while idle");
	a_rdata_holds: assert property (!read_in |=> $stable(readdata_out))
		else $error("read data moved");
	a_clear_reads_zero: assert property (acc && address_in == `TC_REG_CLR |->
		readdata_out == 32'h0) else $error("clear index not zero");
	a_upper_half_zero: assert property (acc && address_in inside {3'h1, 3'h2, 3'h3, 3'h4} |->
		readdata_out[31:16] == 16'h0) else $error("upper half set");
	a_mask_drops_irq: assert property (bus_mode_in && write_in && !waitrequest_out &&
		address_in == `TC_REG_IEN && writedata_in[2:0] == 3'h0 |-> ##2 !timer_irq_out)
		else $error("masked irq high");
	a_alone_irq_pulse: assert property (!bus_mode_in && timer_irq_out |=> !timer_irq_out)
		else $error("irq not a pulse");
	a_wake_pulse_once: assert property (!bus_mode_in && wake_irq_out |=> !wake_irq_out)
		else $error("wake not a pulse");
	a_reset_quiet: assert property ($rose(reset_n_in) |->
		!timer_irq_out && !wake_irq_out && !compare_output_out) else $error("outputs after reset");
	// Main scenarios reached
	c_read_done: cover property (acc);
	c_irq_level: cover property (bus_mode_in && timer_irq_out);
	c_wake_alone: cover property (!bus_mode_in && wake_irq_out);
endmodule // timer_counter_properties
bind timer_counter timer_counter_properties u_props (.core_clk_in, .reset_n_in, .address_in,
	.read_in, .write_in, .writedata_in, .readdata_out, .waitrequest_out, .bus_mode_in,
	.compare_output_out, .timer_irq_out, .wake_irq_out);
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`include "timer_counter_regs.vh"
`default_nettype none
module tb_top;
	logic core_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic bus_mode_in = 1'b1;
	logic timer_clock_in = 1'b0;
	logic timer_reset_n_in = 1'b1;
	logic capture_trigger_in = 1'b0;
	wire [2:0] address_in;
	wire read_in, write_in, waitrequest_out;
	wire [31:0] writedata_in, readdata_out;
	wire compare_output_out, timer_irq_out, wake_irq_out;
	int n_fail = 0, comparisons = 0, irq_n = 0, wake_n = 0, i;
	logic [31:0] q;
	timer_counter dut (.core_clk_in, .reset_n_in, .address_in, .read_in, .write_in,
		.writedata_in, .readdata_out, .waitrequest_out, .bus_mode_in, .timer_clock_in,
		.timer_reset_n_in, .capture_trigger_in, .compare_output_out, .timer_irq_out, .wake_irq_out);
	avalon_host host (.core_clk_in, .waitrequest_out, .readdata_out, .address_in, .read_in,
		.write_in, .writedata_in);
	// 25 MHz clock
	initial forever #20 core_clk_in = ~core_clk_in;
	// Interrupt pulse counters
	always @(posedge core_clk_in) begin
		if (timer_irq_out === 1'b1) irq_n++;
		if (wake_irq_out === 1'b1) wake_n++;
	end
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			$display("Error at %0t: got %h expected %h", $time, g, e);
			n_fail++;
		end
	endtask
	task wr(input logic [2:0] a, input logic [31:0] d);
		host.xfer(1'b0, a, d, q);
	endtask
	task rc(input logic [2:0] a, input logic [31:0] e);
		host.xfer(1'b1, a, 32'h0, q);
		chk(q, e);
	endtask
	task tick(input int n);
		repeat (n) begin
			@(posedge core_clk_in) timer_clock_in <= 1'b1;
			repeat (4) @(posedge core_clk_in);
			timer_clock_in <= 1'b0;
			repeat (4) @(posedge core_clk_in);
		end
	endtask
	task pin_reset();
		@(posedge core_clk_in) timer_reset_n_in <= 1'b0;
		repeat (8) @(posedge core_clk_in);
		timer_reset_n_in <= 1'b1;
		repeat (8) @(posedge core_clk_in);
	endtask
	task trig(input logic v);
		@(posedge core_clk_in) capture_trigger_in <= v;
		repeat (8) @(posedge core_clk_in);
	endtask
	task tally_and_finish();
		n_fail += host.stalls;
		$display("Counts: %0d compared, %0d failed", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task t_reset_values();
		rc(`TC_REG_CTRL, 32'h84);
		rc(`TC_REG_TOP, 32'hffff);
		rc(`TC_REG_CMP, 32'h8000);
		rc(`TC_REG_STAT, 32'h0);
		rc(`TC_REG_IEN, 32'h0);
		rc(`TC_REG_CLR, 32'h0);
		$display("reset values done");
	endtask
	task t_count();
		wr(`TC_REG_CTRL, 32'h84);
		wr(`TC_REG_CNT, 32'h3);
		tick(2);
		rc(`TC_REG_CNT, 32'h1);
		tick(4);
		host.xfer(1'b1, `TC_REG_STAT, 32'h0, q);
		chk({31'h0, q[`TC_EV_OVF]}, 32'h1);
		wr(`TC_REG_CTRL, 32'h8c);
		wr(`TC_REG_CNT, 32'h10);
		tick(4);
		rc(`TC_REG_CNT, 32'he);
		$display("count and prescale done");
	endtask
	task t_irq();
		wr(`TC_REG_CMP, 32'h10);
		wr(`TC_REG_CTRL, 32'h81);
		q = 32'h0;
		for (i = 0; i < 10 && !q[`TC_EV_CMP]; i++) host.xfer(1'b1, `TC_REG_STAT, 32'h0, q);
		chk({31'h0, q[`TC_EV_CMP]}, 32'h1);
		chk({31'h0, timer_irq_out}, 32'h0);
		wr(`TC_REG_IEN, 32'h2);
		repeat (2) @(negedge core_clk_in);
		chk({31'h0, timer_irq_out}, 32'h1);
		wr(`TC_REG_CTRL, 32'h85);
		wr(`TC_REG_CLR, 32'h7);
		rc(`TC_REG_STAT, 32'h0);
		wr(`TC_REG_IEN, 32'h0);
		$display("interrupt done");
	endtask
	task t_capture();
		wr(`TC_REG_CTRL, 32'hc5);
		wr(`TC_REG_CNT, 32'h1234);
		trig(1'b1);
		wr(`TC_REG_CNT, 32'h5678);
		trig(1'b0);
		rc(`TC_REG_CAP, 32'h1234);
		rc(`TC_REG_STAT, 32'h4);
		wr(`TC_REG_CTRL, 32'hc6);
		wr(`TC_REG_CLR, 32'h7);
		trig(1'b1);
		trig(1'b0);
		rc(`TC_REG_STAT, 32'h0);
		$display("capture done");
	endtask
	task t_pwm();
		wr(`TC_REG_TOP, 32'h3);
		wr(`TC_REG_CMP, 32'h2);
		wr(`TC_REG_CTRL, 32'h86);
		pin_reset();
		rc(`TC_REG_CNT, 32'h0);
		for (i = 0; i < 4; i++) begin
			tick(1);
			chk({31'h0, compare_output_out}, {31'h0, i == 0 || i == 3});
		end
		wr(`TC_REG_CTRL, 32'h87);
		pin_reset();
		tick(4);
		rc(`TC_REG_CNT, 32'h2);
		$display("pwm done");
	endtask
	task t_standalone();
		@(posedge core_clk_in) bus_mode_in <= 1'b0;
		reset_n_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		irq_n = 0;
		wake_n = 0;
		wr(`TC_REG_CTRL, 32'h80);
		repeat (10) @(posedge core_clk_in);
		chk(irq_n, 0);
		tick(2);
		chk({31'h0, irq_n != 0}, 32'h1);
		chk({31'h0, wake_n != 0}, 32'h1);
		rc(`TC_REG_CTRL, 32'h84);
		$display("stand-alone done");
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		t_reset_values();
		t_count();
		t_irq();
		t_capture();
		t_pwm();
		t_standalone();
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
